// ===== logic/btp_pkg.sv
// Package for the bit timing phase lock: constants and carrier types
package btp_pkg;

  // ----------------------------------------
  // Reset values and timing counts
  // ----------------------------------------
  localparam logic       RST_LEVEL      = 1'b0;
  localparam int         PULSES_PER_BIT = 200;
  localparam int         DIVIDE_BY      = 2;
  localparam logic [7:0] DEF_OSC_DIV    = 8'h32;

  // Start-stop measurement length in half bits (six and a half bits, 5-level)
  localparam int         SS_HALF_BITS   = 13;
  localparam logic [3:0] SS_HALF_BITS_W = 4'hd;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic early;
    logic late;
  } btp_phase_t;

  typedef struct packed {
    logic insert_pending;
    logic delete_pending;
    logic late_div;
    logic early_div;
  } btp_status_t;

  typedef enum logic [1:0] {
    BTP_IDLE = 2'b00,
    BTP_RUN  = 2'b01
  } btp_ss_state_t;

endpackage

// ===== logic/btp_phase_lock.sv
// Bit timing phase lock: repeats and corrects the 200x bit-rate timing stream
//
// Notes on behaviour
// - Timing stream always passes the pulse repeater; its output is the basic timing.
// - Alignment happens only by inserting or deleting pulses in the timing stream.
// - Early edge deletes a pulse to retard; late edge inserts a pulse.
// - On mark-to-space edge, late phase high means late, otherwise early.
// - Late detections toggle a divide-by-two; every second sets the insert request.
// - Insert request fires an extra pulse on the opposite oscillator phase, mid-gap.
// - The extra pulse clears the insert request, so one pulse per request.
// - Insertion recurs on later late detections until edges are no longer late.
// - Early detections toggle a second divider; every second sets delete, closing gate.
// - The blocked regular pulse slot clears delete, so gate blocks exactly one pulse.
// - Correction at most 1/400 bit per bit, about 1/800 on traffic.
// - Both correction paths stay active after lock.
// - Correction is damped so random edge distortion does not shift phase.
// - Start-stop: first mark-to-space edge starts six and a half bits of timing.
`timescale 1ns/1ps
module btp_phase_lock
  import btp_pkg::*;
#(
  parameter int OSC_DIV_W = 8
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Oscillator stream setup: mclk cycles per half oscillator period
  input  wire logic [OSC_DIV_W-1:0] osc_half_div,
  // Line side (asynchronous), space high, mark low
  input  wire logic                 line_in,
  // Bit-rate phase signals from the analyzer bit counters (same clock)
  input  wire btp_phase_t           phase_in,
  // Mode: high for synchronous lock, low for start-stop
  input  wire logic                 sync_mode,
  // Half-bit enable from the analyzer counters, used for start-stop timing
  input  wire logic                 half_bit_en,
  // Timing outputs
  output logic                      timing_pulse,
  output logic                      ss_active,
  output btp_status_t               status
);

  // ----------------------------------------
  // Oscillator divider: osc rising and falling phase enables
  // ----------------------------------------
  logic [OSC_DIV_W-1:0] div_cnt_ff;
  logic                 osc_ph_ff;
  wire                  div_wrap = (div_cnt_ff == '0);
  wire                  osc_rise = div_wrap && !osc_ph_ff;
  wire                  osc_fall = div_wrap && osc_ph_ff;
  wire [OSC_DIV_W-1:0]  div_load = (osc_half_div == '0) ? OSC_DIV_W'(1) : osc_half_div;

  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt_ff <= '0;
      osc_ph_ff  <= RST_LEVEL;
    end else begin
      div_cnt_ff <= div_wrap ? div_load - OSC_DIV_W'(1) : div_cnt_ff - OSC_DIV_W'(1);
      if (div_wrap) begin
        osc_ph_ff <= !osc_ph_ff;
      end
    end
  end

  // ----------------------------------------
  // Line input synchroniser and edge detect
  // ----------------------------------------
  logic line_s1_ff;
  logic line_s2_ff;
  logic line_d_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      line_s1_ff <= RST_LEVEL;
      line_s2_ff <= RST_LEVEL;
      line_d_ff  <= RST_LEVEL;
    end else begin
      line_s1_ff <= line_in;
      line_s2_ff <= line_s1_ff;
      line_d_ff  <= line_s2_ff;
    end
  end

  // Mark is low, space is high: a rising level is the mark-to-space edge
  wire ms_edge   = line_s2_ff && !line_d_ff;
  wire hit_late  = ms_edge && sync_mode && phase_in.late;
  wire hit_early = ms_edge && sync_mode && !phase_in.late;

  // ----------------------------------------
  // Correction dividers and request flip-flops
  // ----------------------------------------
  // Halving the detections damps the loop against single distorted edges
  logic late_divider_stage_ff;
  logic early_divider_stage_ff;
  logic insert_request_ff;
  logic delete_request_ff;
  logic ins_used_ff;
  logic del_used_ff;

  wire late_carry  = hit_late && late_divider_stage_ff;
  wire early_carry = hit_early && early_divider_stage_ff;

  // Set wins over the repeater clear, so a request is never lost.
  // Each request is cleared only by the repeater slot that served it, so a
  // regular pulse cannot eat an insert and an extra pulse cannot eat a delete.
  wire nxt_insert = late_carry || (insert_request_ff && !ins_used_ff);
  wire nxt_delete = early_carry || (delete_request_ff && !del_used_ff);

  always_ff @(posedge mclk) begin
    if (rst) begin
      late_divider_stage_ff  <= RST_LEVEL;
      early_divider_stage_ff <= RST_LEVEL;
      insert_request_ff      <= RST_LEVEL;
      delete_request_ff      <= RST_LEVEL;
    end else begin
      late_divider_stage_ff  <= late_divider_stage_ff ^ hit_late;
      early_divider_stage_ff <= early_divider_stage_ff ^ hit_early;
      insert_request_ff      <= nxt_insert;
      delete_request_ff      <= nxt_delete;
    end
  end

  // ----------------------------------------
  // Stop gate, extra pulse and pulse repeater
  // ----------------------------------------
  // Delete masks one regular pulse; insert fires on the opposite phase mid-gap
  wire stream_stop_gate      = osc_rise && !delete_request_ff;
  wire extra_pulse_oneshot   = osc_fall && insert_request_ff;
  wire pulse_repeater_oneshot = stream_stop_gate || extra_pulse_oneshot;

  // The gated-off pulse still clears delete: its slot counts as consumed
  wire nxt_del_used = osc_rise && delete_request_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ins_used_ff  <= RST_LEVEL;
      del_used_ff  <= RST_LEVEL;
      timing_pulse <= RST_LEVEL;
    end else begin
      ins_used_ff  <= extra_pulse_oneshot;
      del_used_ff  <= nxt_del_used;
      timing_pulse <= pulse_repeater_oneshot;
    end
  end

  // ----------------------------------------
  // Start-stop character timing
  // ----------------------------------------
  btp_ss_state_t ss_state_ff;
  logic [3:0]    ss_cnt_ff;
  wire           ss_start = ms_edge && !sync_mode && (ss_state_ff == BTP_IDLE);
  wire           ss_done  = half_bit_en && (ss_cnt_ff == SS_HALF_BITS_W - 4'h1);

  always_ff @(posedge mclk) begin
    if (rst) begin
      ss_state_ff <= BTP_IDLE;
      ss_cnt_ff   <= 4'h0;
    end else begin
      unique case (ss_state_ff)
        BTP_IDLE: begin
          ss_cnt_ff <= 4'h0;
          if (ss_start) begin
            ss_state_ff <= BTP_RUN;
          end
        end
        BTP_RUN: begin
          if (ss_done || sync_mode) begin
            ss_state_ff <= BTP_IDLE;
          end else if (half_bit_en) begin
            ss_cnt_ff <= ss_cnt_ff + 4'h1;
          end
        end
        default: begin
          ss_state_ff <= BTP_IDLE;
        end
      endcase
    end
  end

  assign ss_active = sync_mode || (ss_state_ff == BTP_RUN);

  // ----------------------------------------
  // Status
  // ----------------------------------------
  assign status = '{insert_pending: insert_request_ff, delete_pending: delete_request_ff,
                    late_div: late_divider_stage_ff, early_div: early_divider_stage_ff};

endmodule

// ===== dv/btp_phase_lock_assertions.sv
// Port checker for the bit timing phase lock
`timescale 1ns/1ps
module btp_checker
  import btp_pkg::*;
#(
  parameter int OSC_DIV_W = 8
) (
  // Inputs of the block
  input wire logic                 mclk,
  input wire logic                 rst,
  input wire logic [OSC_DIV_W-1:0] osc_half_div,
  input wire logic                 line_in,
  input wire btp_phase_t           phase_in,
  input wire logic                 sync_mode,
  input wire logic                 half_bit_en,
  // Outputs of the block
  input wire logic                 timing_pulse,
  input wire logic                 ss_active,
  input wire btp_status_t          status
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Delay bounds below are only checked for half oscillator periods of 3 to 8 mclk cycles
  wire slow = osc_half_div > 2 && osc_half_div < 9;
  AST_PULSE_ONE: assert property (slow && timing_pulse |=> !timing_pulse) else $error("pulse width");
  AST_INS_SET: assert property ($fell(status.late_div) |-> ##[0:1] status.insert_pending) else $error("ins set");
  AST_DEL_SET: assert property ($fell(status.early_div) |-> ##[0:1] status.delete_pending) else $error("del set");
  AST_INS_CLR: assert property (slow && $rose(status.insert_pending) |-> ##[1:40] !status.insert_pending)
    else $error("ins clear");
  AST_DEL_CLR: assert property (slow && $rose(status.delete_pending) |-> ##[1:40] !status.delete_pending)
    else $error("del clear");
  AST_INS_PULSE: assert property ($fell(status.insert_pending) |-> $past(timing_pulse)) else $error("ins pulse");
  AST_DEL_GATE: assert property ($fell(status.delete_pending) |-> !$past(timing_pulse)) else $error("del gate");
  AST_SS_NOCORR: assert property (!sync_mode && !$past(sync_mode) |-> $stable(status.late_div))
    else $error("ss corr");
  AST_SS_SYNC: assert property (sync_mode |-> ss_active) else $error("ss sync");
endmodule

bind btp_phase_lock btp_checker #(.OSC_DIV_W(OSC_DIV_W)) u_chk (.mclk(mclk), .rst(rst), .osc_half_div(osc_half_div),
  .line_in(line_in), .phase_in(phase_in), .sync_mode(sync_mode), .half_bit_en(half_bit_en),
  .timing_pulse(timing_pulse), .ss_active(ss_active), .status(status));

// ===== dv/btp_line_src.sv
// Line-side source: synchronous telegraph signal, space high and mark low
`timescale 1ns/1ps
module btp_line_src #(
  parameter int HALF_NS = 3700
) (
  // Control
  input  wire logic en,
  // Line replica
  output logic      line_in
);
  int sd = 41;
  initial begin
    line_in = 1'b0;
    forever begin
      // Whole clock periods keep edges off the sampling edge; small drift stays near the rate
      #(HALF_NS + 100 * ($random(sd) & 1));
      if (en) line_in = ~line_in;
    end
  end
endmodule

// ===== dv/tb.sv
// Self-checking bench for the bit timing phase lock
`timescale 1ns/1ps
module tb;
  import btp_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  osc_half_div = 8'h05;
  btp_phase_t  phase_in = '0;
  logic        sync_mode = 1'b1;
  logic        half_bit_en = 1'b0;
  logic        en = 1'b0;
  logic        line_in, timing_pulse, ss_active;
  btp_status_t status;
  logic [2:0]  sh = 3'h0;
  int          fails, checks_done, cyc, t0, d, nl, ne, ni, nd, np;
  int          seed = 41;
  always #50 mclk = ~mclk;
  btp_line_src u_src (.en(en), .line_in(line_in));
  btp_phase_lock uut (.mclk(mclk), .rst(rst), .osc_half_div(osc_half_div), .line_in(line_in), .phase_in(phase_in),
    .sync_mode(sync_mode), .half_bit_en(half_bit_en), .timing_pulse(timing_pulse), .ss_active(ss_active),
    .status(status));
  // Reference: two-stage synchroniser, then late or early per mark-to-space edge
  always @(posedge mclk) begin
    sh <= {sh[1:0], line_in};
    cyc <= cyc + 1;
    if (!rst && sh[1] && !sh[2] && sync_mode) begin
      if (phase_in.late) nl <= nl + 1;
      else ne <= ne + 1;
    end
    if (!rst && timing_pulse) np <= np + 1;
    if (!rst && $rose(status.insert_pending)) ni <= ni + 1;
    if (!rst && $rose(status.delete_pending)) nd <= nd + 1;
    if (cyc > 10000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0d seen %0d", name, exp, seen);
    end
  endtask
  task automatic run(int n);
    repeat (n) begin
      @(negedge mclk);
      half_bit_en = ($random(seed) & 3) == 0;
      // Phase report only moves while no edge is in the synchroniser
      if (sh == {3{line_in}} && ($random(seed) & 7) == 0) phase_in = btp_phase_t'($random(seed));
    end
  endtask
  task automatic phase(logic m, logic [7:0] div);
    @(negedge mclk);
    {rst, sync_mode, osc_half_div} = {1'b1, m, div};
    {nl, ne, ni, nd, np} = '0;
    run(2);
    rst = 1'b0;
    t0 = cyc;
    en = 1'b1;
    run(3000);
    en = 1'b0;
    run(400);
    check("inserts", ni, nl / 2);
    check("deletes", nd, ne / 2);
    d = np - ((cyc - t0) / (2 * div) + ni - nd);
    check("balance", d >= -1 && d <= 1, 1);
    check("window", ss_active, m);
  endtask
  task automatic give_verdict();
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    phase(1'b1, 8'h05);
    phase(1'b0, 8'h07);
    give_verdict();
  end
endmodule
